// [include/mmd_pkg.sv]
package mmd_pkg;

  localparam int unsigned ADDR_BITS = 16;

  // Plain windows of the 64 Kbyte space
  localparam logic [15:0] IO_LO   = 16'h0000;
  localparam logic [15:0] IO_HI   = 16'h003F;
  localparam logic [15:0] RAM_LO  = 16'h0040;
  localparam logic [15:0] RAM_HI  = 16'h043F;
  localparam logic [15:0] RSV_LO  = 16'h0500;
  localparam logic [15:0] RSV_HI  = 16'h057F;
  localparam logic [15:0] PROM_LO = 16'h1C00;
  localparam logic [15:0] PROM_HI = 16'h1D95;
  localparam logic [15:0] UFL_LO  = 16'hC000;
  localparam logic [15:0] UFL_HI  = 16'hFDFF;
  localparam logic [15:0] MON_LO  = 16'hFE20;
  localparam logic [15:0] MON_HI  = 16'hFF7D;
  localparam logic [15:0] VEC_LO  = 16'hFFDC;
  localparam logic [15:0] VEC_HI  = 16'hFFFF;
  localparam logic [15:0] SEC_LO  = 16'hFFF6;
  localparam logic [15:0] SEC_HI  = 16'hFFFD;

  // Single-byte system registers in the high page
  localparam logic [15:0] BRK_STAT_ADDR   = 16'hFE00;
  localparam logic [15:0] RST_CAUSE_ADDR  = 16'hFE01;
  localparam logic [15:0] RSV_A_ADDR      = 16'hFE02;
  localparam logic [15:0] BRK_FLAG_ADDR   = 16'hFE03;
  localparam logic [15:0] IRQ_ONE_ADDR    = 16'hFE04;
  localparam logic [15:0] IRQ_TWO_ADDR    = 16'hFE05;
  localparam logic [15:0] IRQ_THREE_ADDR  = 16'hFE06;
  localparam logic [15:0] RSV_B_ADDR      = 16'hFE07;
  localparam logic [15:0] FLASH_CTRL_ADDR = 16'hFE08;
  localparam logic [15:0] BRK_HIGH_ADDR   = 16'hFE09;
  localparam logic [15:0] BRK_LOW_ADDR    = 16'hFE0A;
  localparam logic [15:0] BRK_SCTL_ADDR   = 16'hFE0B;
  localparam logic [15:0] LOW_VOLT_ADDR   = 16'hFE0C;
  localparam logic [15:0] FLASH_PROT_ADDR = 16'hFF7E;

  // Unimplemented gaps swept by the decoder's own checks
  localparam logic [15:0] SYS_GAP_LO = 16'hFE0D;
  localparam logic [15:0] SYS_GAP_HI = 16'hFE1F;
  localparam logic [15:0] MID_GAP_LO = 16'h1D96;
  localparam logic [15:0] MID_GAP_HI = 16'hBFFF;

  typedef enum logic [4:0] {
    TGT_NONE,
    TGT_IO_PAGE,
    TGT_RAM,
    TGT_PROG_ROM,
    TGT_USER_FLASH,
    TGT_MONITOR_ROM,
    TGT_VECTORS,
    TGT_BREAK_STATUS,
    TGT_RESET_CAUSE,
    TGT_BREAK_FLAG_CTRL,
    TGT_IRQ_ONE,
    TGT_IRQ_TWO,
    TGT_IRQ_THREE,
    TGT_FLASH_CTRL,
    TGT_BREAK_ADDR_HIGH,
    TGT_BREAK_ADDR_LOW,
    TGT_BREAK_STATUS_CTRL,
    TGT_LOW_VOLTAGE,
    TGT_FLASH_PROTECT
  } mmd_target_type;

  localparam int unsigned NUM_SEL = 18;

  function automatic logic mmd_in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
    mmd_in_range = (a >= lo) && (a <= hi);
  endfunction : mmd_in_range

  // Bit t-1 of the select vector stands for target t; no access gives all zero
  function automatic logic [NUM_SEL-1:0] mmd_onehot(input mmd_target_type t);
    logic [NUM_SEL:0] wide;
    wide = '0;
    wide[t] = 1'b1;
    mmd_onehot = wide[NUM_SEL:1];
  endfunction : mmd_onehot

endpackage : mmd_pkg

// [include/mmd_dec_if.sv]
`timescale 1ns/1ps
interface mmd_dec_if;
  import mmd_pkg::*;
  logic [15:0]    addr;
  mmd_target_type target;
  logic [15:0]    offset;
  logic           unimpl;
  logic           reserved;
  logic           secure;

  modport dec  (input addr, output target, output offset, output unimpl, output reserved, output secure);
  modport user (output addr, input target, input offset, input unimpl, input reserved, input secure);
endinterface : mmd_dec_if

// [src/mmd_range_decode.sv]
`timescale 1ns/1ps
module mmd_range_decode
  import mmd_pkg::*;
(
  mmd_dec_if.dec bus
);

  logic [15:0] base;

  always_comb
  begin
    bus.target   = TGT_NONE;
    base         = bus.addr;
    bus.reserved = 1'b0;
    if (mmd_in_range(bus.addr, IO_LO, IO_HI))
    begin
      bus.target = TGT_IO_PAGE;
      base       = IO_LO;
    end
    else if (mmd_in_range(bus.addr, RAM_LO, RAM_HI))
    begin
      bus.target = TGT_RAM;
      base       = RAM_LO;
    end
    else if (mmd_in_range(bus.addr, PROM_LO, PROM_HI))
    begin
      bus.target = TGT_PROG_ROM;
      base       = PROM_LO;
    end
    else if (mmd_in_range(bus.addr, UFL_LO, UFL_HI))
    begin
      bus.target = TGT_USER_FLASH;
      base       = UFL_LO;
    end
    else if (mmd_in_range(bus.addr, MON_LO, MON_HI))
    begin
      bus.target = TGT_MONITOR_ROM;
      base       = MON_LO;
    end
    else if (mmd_in_range(bus.addr, VEC_LO, VEC_HI))
    begin
      bus.target = TGT_VECTORS;
      base       = VEC_LO;
    end
    else if (mmd_in_range(bus.addr, RSV_LO, RSV_HI))
      bus.reserved = 1'b1;
    else
    begin
      unique case (bus.addr)
        BRK_STAT_ADDR:   bus.target = TGT_BREAK_STATUS;
        RST_CAUSE_ADDR:  bus.target = TGT_RESET_CAUSE;
        BRK_FLAG_ADDR:   bus.target = TGT_BREAK_FLAG_CTRL;
        IRQ_ONE_ADDR:    bus.target = TGT_IRQ_ONE;
        IRQ_TWO_ADDR:    bus.target = TGT_IRQ_TWO;
        IRQ_THREE_ADDR:  bus.target = TGT_IRQ_THREE;
        FLASH_CTRL_ADDR: bus.target = TGT_FLASH_CTRL;
        BRK_HIGH_ADDR:   bus.target = TGT_BREAK_ADDR_HIGH;
        BRK_LOW_ADDR:    bus.target = TGT_BREAK_ADDR_LOW;
        BRK_SCTL_ADDR:   bus.target = TGT_BREAK_STATUS_CTRL;
        LOW_VOLT_ADDR:   bus.target = TGT_LOW_VOLTAGE;
        FLASH_PROT_ADDR: bus.target = TGT_FLASH_PROTECT;
        RSV_A_ADDR,
        RSV_B_ADDR:      bus.reserved = 1'b1;
        default:         bus.target = TGT_NONE;
      endcase
    end
    bus.offset = bus.addr - base;
    bus.unimpl = (bus.target == TGT_NONE) && !bus.reserved;
    bus.secure = mmd_in_range(bus.addr, SEC_LO, SEC_HI);
  end

endmodule : mmd_range_decode

// [src/mmd_address_decoder.sv]
`timescale 1ns/1ps
module mmd_address_decoder
  import mmd_pkg::*;
#(
  parameter int unsigned ADDR_W = ADDR_BITS
)
(
  input  wire logic                clk,
  input  wire logic                srst,
  input  wire logic                clk_en,
  input  wire logic [ADDR_W-1:0]   cpu_addr,
  input  wire logic                cpu_access,
  input  wire logic                cpu_write,
  input  wire logic                illegal_rst_en,
  output logic [NUM_SEL-1:0]       target_sel_reg,
  output mmd_target_type           target_id_reg,
  output logic [ADDR_W-1:0]        local_offset_reg,
  output logic                     write_reg,
  output logic                     unimpl_reg,
  output logic                     reserved_reg,
  output logic                     security_byte_reg,
  output logic                     illegal_addr_rst_reg
);

  // The map is fixed to a flat 64 Kbyte space
  if (ADDR_W != ADDR_BITS)
  begin : g_width_check
    $error("mmd_address_decoder: ADDR_W must be 16");
  end

  mmd_dec_if dec_bus ();

  logic [NUM_SEL-1:0] target_sel_next;
  mmd_target_type     target_id_next;
  logic [ADDR_W-1:0]  local_offset_next;
  logic               write_next;
  logic               unimpl_next;
  logic               reserved_next;
  logic               security_byte_next;
  logic               illegal_addr_rst_next;

  assign dec_bus.addr = cpu_addr;

  mmd_range_decode u_range (
    .bus (dec_bus)
  );

  // Outputs are registered, so each decode shows one edge after the access
  always_comb
  begin
    target_sel_next       = '0;
    target_id_next        = TGT_NONE;
    local_offset_next     = '0;
    write_next            = 1'b0;
    unimpl_next           = 1'b0;
    reserved_next         = 1'b0;
    security_byte_next    = 1'b0;
    illegal_addr_rst_next = 1'b0;
    if (cpu_access)
    begin
      target_id_next        = dec_bus.target;
      target_sel_next       = mmd_onehot(dec_bus.target);
      local_offset_next     = dec_bus.offset;
      write_next            = cpu_write;
      unimpl_next           = dec_bus.unimpl;
      // Reserved space has no defined answer; flag it and select nothing
      reserved_next         = dec_bus.reserved;
      security_byte_next    = dec_bus.secure;
      illegal_addr_rst_next = dec_bus.unimpl && illegal_rst_en;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      target_sel_reg       <= '0;
      target_id_reg        <= TGT_NONE;
      local_offset_reg     <= '0;
      write_reg            <= 1'b0;
      unimpl_reg           <= 1'b0;
      reserved_reg         <= 1'b0;
      security_byte_reg    <= 1'b0;
      illegal_addr_rst_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      target_sel_reg       <= target_sel_next;
      target_id_reg        <= target_id_next;
      local_offset_reg     <= local_offset_next;
      write_reg            <= write_next;
      unimpl_reg           <= unimpl_next;
      reserved_reg         <= reserved_next;
      security_byte_reg    <= security_byte_next;
      illegal_addr_rst_reg <= illegal_addr_rst_next;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence acc_at(logic [15:0] lo, logic [15:0] hi);
    clk_en && cpu_access && mmd_in_range(cpu_addr, lo, hi);
  endsequence

  io_page_sel_a : assert property (acc_at(IO_LO, IO_HI) |=> target_sel_reg == mmd_onehot(TGT_IO_PAGE))
    else $error("zero-page access did not select the register area");

  ram_sel_a : assert property (acc_at(RAM_LO, RAM_HI) |=> target_sel_reg[TGT_RAM - 1] && !unimpl_reg
                               && local_offset_reg == $past(cpu_addr) - RAM_LO)
    else $error("RAM access did not select RAM with the right offset");

  prog_rom_sel_a : assert property (acc_at(PROM_LO, PROM_HI) |=> target_id_reg == TGT_PROG_ROM)
    else $error("programming ROM window not selected");

  user_flash_sel_a : assert property (acc_at(UFL_LO, UFL_HI) |=> target_id_reg == TGT_USER_FLASH)
    else $error("user flash window not selected");

  monitor_rom_sel_a : assert property (acc_at(MON_LO, MON_HI) |=> target_id_reg == TGT_MONITOR_ROM)
    else $error("monitor ROM window not selected");

  vector_sel_a : assert property (acc_at(VEC_LO, VEC_HI) |=> target_id_reg == TGT_VECTORS
                                  && security_byte_reg == mmd_in_range($past(cpu_addr), SEC_LO, SEC_HI))
    else $error("vector area or security byte flag wrong");

  sys_reg_sel_a : assert property (clk_en && cpu_access && cpu_addr == IRQ_TWO_ADDR
                                   |=> target_id_reg == TGT_IRQ_TWO)
    else $error("second interrupt status register not selected");

  break_regs_sel_a : assert property (clk_en && cpu_access && cpu_addr == BRK_LOW_ADDR
                                      |=> target_id_reg == TGT_BREAK_ADDR_LOW)
    else $error("break address low byte not selected");

  reset_cause_sel_a : assert property (clk_en && cpu_access && cpu_addr == RST_CAUSE_ADDR
                                       |=> target_id_reg == TGT_RESET_CAUSE)
    else $error("reset cause register not selected");

  protect_sel_a : assert property (clk_en && cpu_access && cpu_addr == FLASH_PROT_ADDR
                                   |=> target_id_reg == TGT_FLASH_PROTECT && !unimpl_reg)
    else $error("flash block protect register not selected");

  unimpl_gap_a : assert property (acc_at(SYS_GAP_LO, SYS_GAP_HI) or acc_at(MID_GAP_LO, MID_GAP_HI)
                                  |=> unimpl_reg && target_sel_reg == '0
                                  && illegal_addr_rst_reg == $past(illegal_rst_en))
    else $error("gap access not flagged as unimplemented");

  one_select_a : assert property ($onehot0(target_sel_reg) && !(unimpl_reg && reserved_reg)
                                  && ((target_sel_reg != '0) || unimpl_reg || reserved_reg
                                      || !$past(cpu_access && clk_en && !srst)))
    else $error("select vector not one-hot or access left unclassified");

  illegal_pulse_a : assert property (illegal_addr_rst_reg |-> unimpl_reg)
    else $error("illegal-address reset without an unimplemented access");

  idle_quiet_a : assert property (clk_en && !cpu_access |=> target_sel_reg == '0 && !illegal_addr_rst_reg)
    else $error("outputs active without an access");

  ram_cov_c      : cover property (acc_at(RAM_LO, RAM_HI) ##1 target_sel_reg[TGT_RAM - 1]);
  secure_cov_c   : cover property (acc_at(SEC_LO, SEC_HI) ##1 security_byte_reg);
  illegal_cov_c  : cover property (illegal_addr_rst_reg);
  reserved_cov_c : cover property (reserved_reg);

endmodule : mmd_address_decoder

// [verification/mmd_core_model.sv]
`timescale 1ns/1ps
module mmd_core_model
(
  output logic [15:0] cpu_addr,
  output logic        cpu_access,
  output logic        cpu_write
);
  logic [15:0] last_addr;
  initial
  begin
    cpu_addr = 16'h0000;
    cpu_access = 1'b0;
    cpu_write = 1'b0;
    last_addr = 16'h0000;
  end
  // Idle cycles show the complement of the last accessed address and toggle write, so a stale decode cannot pass
  task automatic issue(input logic [15:0] a, input logic acc, input logic wr);
    cpu_access = acc;
    cpu_write = acc ? wr : ~cpu_write;
    cpu_addr = acc ? a : ~last_addr;
    if (acc)
      last_addr = a;
  endtask : issue
  // Random traffic keeps clear of reserved places; directed tests hit them on purpose
  function automatic logic [15:0] steer(input logic [15:0] a);
    if (a inside {[16'h0500:16'h057F], 16'hFE02, 16'hFE07})
      steer = a ^ 16'h8000;
    else
      steer = a;
  endfunction : steer
endmodule : mmd_core_model

// [verification/memory_map_address_decoder_bench.sv]
`timescale 1ns/1ps
module memory_map_address_decoder_bench;
  import mmd_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b0;
  logic illegal_rst_en = 1'b0;
  logic [15:0] cpu_addr;
  logic cpu_access;
  logic cpu_write;
  logic [NUM_SEL-1:0] target_sel_reg;
  mmd_target_type target_id_reg;
  logic [15:0] local_offset_reg;
  logic write_reg, unimpl_reg, reserved_reg, security_byte_reg, illegal_addr_rst_reg;
  int err_total = 0;
  int check_count = 0;
  logic [17:0] e_sel;
  logic [31:0] e_id, e_off, e_wr, e_un, e_rs, e_sec, e_ill;
  logic [31:0] lfsr = 32'hF37C;
  int lo_t [18] = '{16'h0000, 16'h0040, 16'h1C00, 16'hC000, 16'hFE20, 16'hFFDC, 16'hFE00, 16'hFE01, 16'hFE03,
                    16'hFE04, 16'hFE05, 16'hFE06, 16'hFE08, 16'hFE09, 16'hFE0A, 16'hFE0B, 16'hFE0C, 16'hFF7E};
  int hi_t [18] = '{16'h003F, 16'h043F, 16'h1D95, 16'hFDFF, 16'hFF7D, 16'hFFFF, 16'hFE00, 16'hFE01, 16'hFE03,
                    16'hFE04, 16'hFE05, 16'hFE06, 16'hFE08, 16'hFE09, 16'hFE0A, 16'hFE0B, 16'hFE0C, 16'hFF7E};
  int extra [16] = '{16'hFE0F, 16'hFE10, 16'hFFF5, 16'hFFF6, 16'hFFFD, 16'hFFFE, 16'h0500, 16'h057F,
                     16'hFE02, 16'hFE07, 16'h04FF, 16'h0580, 16'h1BFF, 16'hBFFF, 16'hFF7F, 16'hFFDB};

  initial
  begin
    forever #20 clk = ~clk;
  end

  mmd_core_model u_mmd_core_model (.cpu_addr(cpu_addr), .cpu_access(cpu_access), .cpu_write(cpu_write));

  mmd_address_decoder u_mmd_address_decoder (
    .clk                  (clk),
    .srst                 (srst),
    .clk_en               (clk_en),
    .cpu_addr             (cpu_addr),
    .cpu_access           (cpu_access),
    .cpu_write            (cpu_write),
    .illegal_rst_en       (illegal_rst_en),
    .target_sel_reg       (target_sel_reg),
    .target_id_reg        (target_id_reg),
    .local_offset_reg     (local_offset_reg),
    .write_reg            (write_reg),
    .unimpl_reg           (unimpl_reg),
    .reserved_reg         (reserved_reg),
    .security_byte_reg    (security_byte_reg),
    .illegal_addr_rst_reg (illegal_addr_rst_reg)
  );

  task automatic conclude();
    if (err_total == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic step(input logic [15:0] a, input logic acc, input logic wr, input logic en, input logic ill,
                      input logic rst);
    int t;
    int a_i;
    a_i = a;
    srst = rst;
    clk_en = en;
    illegal_rst_en = ill;
    u_mmd_core_model.issue(a, acc, wr);
    @(posedge clk);
    #1;
    if (rst || (en && !acc))
    begin
      {e_sel, e_id, e_off, e_wr, e_un, e_rs, e_sec, e_ill} = '0;
    end
    else if (en)
    begin
      t = 0;
      e_off = 0;
      for (int i = 0; i < 18; i++)
        if (a_i >= lo_t[i] && a_i <= hi_t[i])
        begin
          t = i + 1;
          e_off = a_i - lo_t[i];
        end
      e_rs = (a_i inside {[16'h0500:16'h057F], 16'hFE02, 16'hFE07});
      e_id = t;
      e_sel = (t == 0) ? 18'h00000 : (18'h00001 << (t - 1));
      e_wr = wr;
      e_un = (t == 0) && !e_rs[0];
      e_sec = (a_i >= 16'hFFF6) && (a_i <= 16'hFFFD);
      e_ill = e_un[0] && ill;
    end
    chk(32'(target_sel_reg), 32'(e_sel));
    chk(32'(target_id_reg), e_id);
    chk(32'(local_offset_reg), e_off);
    chk(32'(write_reg), e_wr);
    chk(32'(unimpl_reg), e_un);
    chk(32'(reserved_reg), e_rs);
    chk(32'(security_byte_reg), e_sec);
    chk(32'(illegal_addr_rst_reg), e_ill);
  endtask : step

  initial
  begin
    #(40 * 10000);
    err_total++;
    conclude();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    step(16'h0045, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 18; i++)
    begin
      step(16'(lo_t[i]), 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
      step(16'(hi_t[i]), 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
      step(16'(lo_t[i] - 1), 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      step(16'(hi_t[i] + 1), 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    end
    for (int i = 0; i < 16; i++)
      step(16'(extra[i]), 1'b1, i[0], 1'b1, 1'b1, 1'b0);
    step(16'h0600, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    step(16'h0600, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    step(16'hFE0D, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 2000; i++)
    begin
      lfsr = lfsr_next(lfsr);
      step(u_mmd_core_model.steer(lfsr[15:0]), lfsr[16] | lfsr[17], lfsr[18], lfsr[19] | lfsr[20],
           lfsr[21], lfsr[31:26] == 6'h00);
    end
    conclude();
  end
endmodule : memory_map_address_decoder_bench
